// file: syc_cfg.svh
// Constants of the system clock switch, watchdog, brown-out and wake-up logic.
// Assumes inclusion by bare name from the design modules and the testbench.
`ifndef SYC_CFG_SVH
`define SYC_CFG_SVH

// Clock mode register fields
`define SYC_CM_SEL_HI      7
`define SYC_CM_SEL_LO      5
`define SYC_CM_HRC_EN      4
`define SYC_CM_TYPE        3
`define SYC_CM_LRC_EN      2
`define SYC_CM_WDT_EN      1
`define SYC_CM_RESET       8'hf6

// Documented clock mode values
`define SYC_CM_HRC_DIV2    8'h36
`define SYC_CM_XTAL        8'ha4

// Crystal control register fields
`define SYC_XC_EN          7
`define SYC_XC_DRV_HI      6
`define SYC_XC_DRV_LO      5
`define SYC_XC_RESET       8'h00

// Auxiliary control register fields
`define SYC_AUX_BOR_DIS    2
`define SYC_AUX_WDT_HI     1
`define SYC_AUX_WDT_LO     0
`define SYC_AUX_RESET      8'h00

// Watchdog periods in low-speed RC periods
`define SYC_WDT_P0         8192
`define SYC_WDT_P1         16384
`define SYC_WDT_P2         65536
`define SYC_WDT_P3         262144

// Wake-up times in low-speed RC periods
`define SYC_WAKE_FAST      45
`define SYC_WAKE_SLOW      3000

// Brown-out threshold code shown before power-on completes
`define SYC_BOR_LVL_NONE   3'h0

`endif

// file: syc_pkg.sv
// Types of the system clock switch block.
// Assumes nothing beyond the constants header.
package syc_pkg;

  typedef enum logic [1:0] {
    SYC_SRC_LRC  = 2'b00,
    SYC_SRC_HRC  = 2'b01,
    SYC_SRC_XTAL = 2'b10
  } syc_src_t;

  typedef enum logic {
    SYC_WK_IDLE  = 1'b0,
    SYC_WK_COUNT = 1'b1
  } syc_wake_t;

  typedef struct packed {
    syc_src_t   src;
    logic [6:0] div;
    logic       ok;
  } syc_sel_t;

endpackage

// file: syc_wdt.sv
// Watchdog counter running on low-speed RC ticks.
// Assumes ticks are one-cycle pulses synchronous to clk.
`timescale 1ns/1ps
`include "syc_cfg.svh"
module syc_wdt
  import syc_pkg::*;
#(
  parameter int unsigned P0 = `SYC_WDT_P0,
  parameter int unsigned P1 = `SYC_WDT_P1,
  parameter int unsigned P2 = `SYC_WDT_P2,
  parameter int unsigned P3 = `SYC_WDT_P3
)(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       lrc_tick,
  input  wire logic       lrc_run,
  input  wire logic       wdt_en,
  input  wire logic [1:0] period_sel,
  input  wire logic       wdt_clear,
  output logic            expire
);

  logic [18:0] cnt_reg;
  logic [18:0] lim;

  // ----------------------------------------
  // Period select
  // ----------------------------------------
  always_comb
  begin
    case (period_sel)
      2'h0:    lim = 19'(P0);  // RULE_09
      2'h1:    lim = 19'(P1);  // RULE_09
      2'h2:    lim = 19'(P2);  // RULE_09
      default: lim = 19'(P3);  // RULE_09
    endcase
  end

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    expire <= 1'b0;
    if (!rst_n || !wdt_en || wdt_clear)
      cnt_reg <= 19'h0;  // RULE_07
    else if (lrc_tick && lrc_run)  // RULE_08
    begin
      if (cnt_reg == lim - 19'h1)
      begin
        cnt_reg <= 19'h0;
        expire  <= 1'b1;  // RULE_09
      end
      else
        cnt_reg <= cnt_reg + 19'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_wdt_lrc_off: assert property ( // RULE_08
    !lrc_run && wdt_en && !wdt_clear |=> $stable(cnt_reg))
    else $error("Watchdog counted with low-speed oscillator off");
  a_wdt_off_quiet: assert property (!wdt_en |=> !expire) // RULE_07
    else $error("Watchdog expired while disabled");
  a_wdt_period: assert property ( // RULE_09
    lrc_tick && lrc_run && wdt_en && !wdt_clear && cnt_reg == lim - 19'h1 |=> expire)
    else $error("Watchdog missed its period");

endmodule

// file: syc_top.sv
// System clock switch with watchdog, brown-out gating and wake-up timer.
// Assumes oscillator ticks are one-cycle pulses synchronous to clk.
//
// Overview of operation
// RULE_01 - Software switches source before stopping old oscillator
// RULE_02 - Clock mode bit 2 clear stops low-speed RC
// RULE_03 - Value 0x36 selects high-speed RC divided two
// RULE_04 - Value 0xA4 selects crystal, low-speed RC stays
// RULE_05 - No crystal stability check before switching
// RULE_06 - Software waits for crystal settling before selecting
// RULE_07 - Clock mode bit 1 enables the watchdog
// RULE_08 - Watchdog counts only while low-speed RC runs
// RULE_09 - Auxiliary field picks four watchdog periods
// RULE_10 - Auxiliary bit 2 set disables brown-out reset
// RULE_11 - Brown-out reset inactive in both stop modes
// RULE_12 - Brown-out threshold valid after power-on completes
// RULE_13 - Fast wake-up resumes after 45 low-speed cycles
// RULE_14 - Low-speed RC divided sixteen is selectable
// RULE_15 - Crystal drive in bits 6:5, enable bit 7
// RULE_16 - Stopped selected source stalls core clock
// RULE_17 - Source change at period boundary, no glitch
`timescale 1ns/1ps
`include "syc_cfg.svh"
module syc_top
  import syc_pkg::*;
#(
  parameter int unsigned WDT_P0    = `SYC_WDT_P0,
  parameter int unsigned WDT_P1    = `SYC_WDT_P1,
  parameter int unsigned WDT_P2    = `SYC_WDT_P2,
  parameter int unsigned WDT_P3    = `SYC_WDT_P3,
  parameter int unsigned WAKE_FAST = `SYC_WAKE_FAST,
  parameter int unsigned WAKE_SLOW = `SYC_WAKE_SLOW,
  parameter logic [2:0]  BOR_LEVEL = 3'h1
)(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       lrc_tick,
  input  wire logic       hrc_tick,
  input  wire logic       xtal_tick,
  input  wire logic       clock_mode_wr,
  input  wire logic [7:0] clock_mode_wdata,
  input  wire logic       crystal_ctrl_wr,
  input  wire logic [7:0] crystal_ctrl_wdata,
  input  wire logic       aux_ctrl_wr,
  input  wire logic [7:0] aux_ctrl_wdata,
  input  wire logic       wdt_clear,
  input  wire logic       por_done,
  input  wire logic       supply_low,
  input  wire logic       light_stop,
  input  wire logic       deep_stop,
  input  wire logic       wake_req,
  input  wire logic       fast_wake_sel,
  output logic [7:0]      clock_mode_q,
  output logic [7:0]      crystal_ctrl_q,
  output logic [7:0]      aux_ctrl_q,
  output logic            lrc_en,
  output logic            hrc_en,
  output logic            xtal_en,
  output logic [1:0]      xtal_drive,
  output logic [1:0]      core_src,
  output logic            core_tick,
  output logic            wdt_reset,
  output logic            brownout_reset,
  output logic [2:0]      brownout_level,
  output logic            wake_done
);

  logic [7:0]  clock_mode_reg;
  logic [7:0]  crystal_ctrl_reg;
  logic [7:0]  aux_ctrl_reg;
  syc_src_t    pend_src_reg;
  logic [6:0]  pend_div_reg;
  syc_src_t    act_src_reg;
  logic [6:0]  act_div_reg;
  logic [6:0]  div_cnt_reg;
  logic        core_tick_reg;
  logic        armed_reg;
  logic        bor_reg;
  logic [2:0]  level_reg;
  syc_wake_t   wake_reg;
  logic [11:0] wake_cnt_reg;
  logic        wake_done_reg;
  logic        src_tick;
  syc_sel_t    new_sel;
  logic [11:0] wake_lim;

  // ----------------------------------------
  // Clock selection decode
  // ----------------------------------------
  function automatic syc_sel_t decode_sel(input logic [3:0] code);
    syc_sel_t s;
    case (code)
      4'h0:    s = '{src: SYC_SRC_HRC,  div: 7'h04, ok: 1'b1};
      4'h1:    s = '{src: SYC_SRC_HRC,  div: 7'h02, ok: 1'b1};
      4'h2:    s = '{src: SYC_SRC_HRC,  div: 7'h01, ok: 1'b1};
      4'h3:    s = '{src: SYC_SRC_XTAL, div: 7'h04, ok: 1'b1};
      4'h4:    s = '{src: SYC_SRC_XTAL, div: 7'h02, ok: 1'b1};
      4'h5:    s = '{src: SYC_SRC_XTAL, div: 7'h01, ok: 1'b1};
      4'h6:    s = '{src: SYC_SRC_LRC,  div: 7'h04, ok: 1'b1};
      4'h7:    s = '{src: SYC_SRC_LRC,  div: 7'h01, ok: 1'b1};
      4'h8:    s = '{src: SYC_SRC_HRC,  div: 7'h10, ok: 1'b1};
      4'h9:    s = '{src: SYC_SRC_HRC,  div: 7'h08, ok: 1'b1};
      4'ha:    s = '{src: SYC_SRC_LRC,  div: 7'h10, ok: 1'b1};  // RULE_14
      4'hb:    s = '{src: SYC_SRC_HRC,  div: 7'h20, ok: 1'b1};
      4'hc:    s = '{src: SYC_SRC_HRC,  div: 7'h40, ok: 1'b1};
      4'hd:    s = '{src: SYC_SRC_XTAL, div: 7'h08, ok: 1'b1};
      default: s = '{src: SYC_SRC_HRC,  div: 7'h01, ok: 1'b0};
    endcase
    return s;
  endfunction

  assign new_sel = decode_sel({clock_mode_wdata[`SYC_CM_TYPE],
                               clock_mode_wdata[`SYC_CM_SEL_HI:`SYC_CM_SEL_LO]});

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      clock_mode_reg <= `SYC_CM_RESET;
    else if (clock_mode_wr)
      clock_mode_reg <= clock_mode_wdata;  // RULE_02
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      crystal_ctrl_reg <= `SYC_XC_RESET;
    else if (crystal_ctrl_wr)
      crystal_ctrl_reg <= crystal_ctrl_wdata;  // RULE_15
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      aux_ctrl_reg <= `SYC_AUX_RESET;
    else if (aux_ctrl_wr)
      aux_ctrl_reg <= aux_ctrl_wdata;
  end
  assign clock_mode_q   = clock_mode_reg;
  assign crystal_ctrl_q = crystal_ctrl_reg;
  assign aux_ctrl_q     = aux_ctrl_reg;
  assign lrc_en         = clock_mode_reg[`SYC_CM_LRC_EN];  // RULE_02
  assign hrc_en         = clock_mode_reg[`SYC_CM_HRC_EN];
  assign xtal_en        = crystal_ctrl_reg[`SYC_XC_EN];  // RULE_15
  assign xtal_drive     = crystal_ctrl_reg[`SYC_XC_DRV_HI:`SYC_XC_DRV_LO];  // RULE_15

  // ----------------------------------------
  // Pending selection, taken at end of write
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pend_src_reg <= SYC_SRC_LRC;
      pend_div_reg <= 7'h01;
    end
    else if (clock_mode_wr && new_sel.ok)
    begin
      pend_src_reg <= new_sel.src;  // RULE_03 RULE_04 RULE_05
      pend_div_reg <= new_sel.div;
    end
  end

  // ----------------------------------------
  // Active source, divider and core tick
  // ----------------------------------------
  always_comb
  begin
    case (act_src_reg)
      SYC_SRC_LRC:  src_tick = lrc_tick && lrc_en;  // RULE_16
      SYC_SRC_HRC:  src_tick = hrc_tick && hrc_en;  // RULE_16
      SYC_SRC_XTAL: src_tick = xtal_tick && xtal_en;  // RULE_16
      default:      src_tick = 1'b0;
    endcase
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      act_src_reg <= SYC_SRC_LRC;
      act_div_reg <= 7'h01;
    end
    else if (div_cnt_reg == 7'h0)
    begin
      act_src_reg <= pend_src_reg;  // RULE_17
      act_div_reg <= pend_div_reg;  // RULE_17
    end
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      div_cnt_reg   <= 7'h0;
      core_tick_reg <= 1'b0;
    end
    else
    begin
      core_tick_reg <= 1'b0;
      if (src_tick)
      begin
        if (div_cnt_reg == act_div_reg - 7'h1)
        begin
          div_cnt_reg   <= 7'h0;
          core_tick_reg <= 1'b1;
        end
        else
          div_cnt_reg <= div_cnt_reg + 7'h1;
      end
    end
  end
  assign core_tick = core_tick_reg;
  assign core_src  = act_src_reg;

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  syc_wdt #(
    .P0 (WDT_P0),
    .P1 (WDT_P1),
    .P2 (WDT_P2),
    .P3 (WDT_P3)
  ) u_wdt (
    .clk        (clk),
    .rst_n      (rst_n),
    .lrc_tick   (lrc_tick),
    .lrc_run    (lrc_en),  // RULE_08
    .wdt_en     (clock_mode_reg[`SYC_CM_WDT_EN]),  // RULE_07
    .period_sel (aux_ctrl_reg[`SYC_AUX_WDT_HI:`SYC_AUX_WDT_LO]),  // RULE_09
    .wdt_clear  (wdt_clear),
    .expire     (wdt_reset)
  );

  // ----------------------------------------
  // Brown-out reset
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      armed_reg <= 1'b0;
    else if (por_done)
      armed_reg <= 1'b1;  // RULE_12
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      level_reg <= `SYC_BOR_LVL_NONE;
    else
      level_reg <= armed_reg ? BOR_LEVEL : `SYC_BOR_LVL_NONE;  // RULE_12
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      bor_reg <= 1'b0;
    else
      bor_reg <= supply_low && armed_reg  // RULE_12
              && !aux_ctrl_reg[`SYC_AUX_BOR_DIS]  // RULE_10
              && !light_stop && !deep_stop;  // RULE_11
  end
  assign brownout_reset = bor_reg;
  assign brownout_level = level_reg;

  // ----------------------------------------
  // Wake-up timer
  // ----------------------------------------
  assign wake_lim = fast_wake_sel ? 12'(WAKE_FAST) : 12'(WAKE_SLOW);
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wake_reg      <= SYC_WK_IDLE;
      wake_cnt_reg  <= 12'h0;
      wake_done_reg <= 1'b0;
    end
    else
    begin
      wake_done_reg <= 1'b0;
      case (wake_reg)
        SYC_WK_IDLE:
        begin
          wake_cnt_reg <= 12'h0;
          if (wake_req)
            wake_reg <= SYC_WK_COUNT;
        end
        SYC_WK_COUNT:
        begin
          if (lrc_tick && lrc_en)
          begin
            if (wake_cnt_reg == wake_lim - 12'h1)
            begin
              wake_done_reg <= 1'b1;  // RULE_13
              wake_reg      <= SYC_WK_IDLE;
            end
            else
              wake_cnt_reg <= wake_cnt_reg + 12'h1;
          end
        end
        default: wake_reg <= SYC_WK_IDLE;
      endcase
    end
  end
  assign wake_done = wake_done_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_write_hrc2;
    clock_mode_wr && clock_mode_wdata == `SYC_CM_HRC_DIV2;
  endsequence
  sequence s_write_xtal;
    clock_mode_wr && clock_mode_wdata == `SYC_CM_XTAL;
  endsequence

  a_hrc_div2_sel: assert property ( // RULE_03
    s_write_hrc2 |=> pend_src_reg == SYC_SRC_HRC && pend_div_reg == 7'h02 && lrc_en)
    else $error("Value 0x36 did not select high-speed RC by two");
  a_xtal_sel: assert property ( // RULE_04
    s_write_xtal |=> pend_src_reg == SYC_SRC_XTAL && pend_div_reg == 7'h01 && lrc_en)
    else $error("Value 0xA4 did not select crystal");
  a_lrc_bit_gate: assert property ( // RULE_02
    clock_mode_wr |=> lrc_en == $past(clock_mode_wdata[`SYC_CM_LRC_EN]))
    else $error("Low-speed enable does not follow bit 2");
  a_switch_boundary: assert property ( // RULE_17
    $changed(act_src_reg) |-> $past(div_cnt_reg) == 7'h0)
    else $error("Source switched inside a core period");
  a_stall_stopped: assert property (!src_tick |=> !core_tick) // RULE_16
    else $error("Core tick without a running source");
  a_bor_stop: assert property (light_stop || deep_stop |=> !brownout_reset) // RULE_11
    else $error("Brown-out reset in stop mode");
  a_bor_disable: assert property (aux_ctrl_reg[`SYC_AUX_BOR_DIS] |=> !brownout_reset) // RULE_10
    else $error("Brown-out reset while disabled");
  a_bor_armed: assert property ( // RULE_12
    !armed_reg |-> brownout_level == `SYC_BOR_LVL_NONE && !brownout_reset)
    else $error("Brown-out active before power-on done");
  a_fast_wake: assert property ( // RULE_13
    wake_done && $past(fast_wake_sel) |-> $past(wake_cnt_reg) == 12'(WAKE_FAST - 1))
    else $error("Fast wake-up count wrong");

endmodule

// file: tb_system_clock_switch_and_wdt.sv
// Self-checking testbench of the system clock switch, watchdog, brown-out and wake-up block.
// Assumes syc_cfg.svh, syc_pkg and syc_top are compiled first; the bench drives every input.
`timescale 1ns/1ps
`include "syc_cfg.svh"
`define CHK(got, exp) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) \
    begin \
      mismatches++; \
      $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end
module tb_system_clock_switch_and_wdt
  import syc_pkg::*;
;
  // ----------------------------------------
  // Signals and clock
  // ----------------------------------------
  logic       clk, rst_n, lrc_tick, hrc_tick, xtal_tick;
  logic       clock_mode_wr, crystal_ctrl_wr, aux_ctrl_wr;
  logic [7:0] clock_mode_wdata, crystal_ctrl_wdata, aux_ctrl_wdata;
  logic       wdt_clear, por_done, supply_low, light_stop, deep_stop, wake_req, fast_wake_sel;
  wire  [7:0] clock_mode_q, crystal_ctrl_q, aux_ctrl_q;
  wire        lrc_en, hrc_en, xtal_en, core_tick, wdt_reset, brownout_reset, wake_done;
  wire  [1:0] xtal_drive, core_src;
  wire  [2:0] brownout_level;
  logic       lrc_on, hrc_on, xtal_on;
  int         cyc, mismatches, n_checks;
  int         wdt_p [4] = '{4, 5, 6, 8};

  always #20 clk = ~clk;

  syc_top #(.WDT_P0(4), .WDT_P1(5), .WDT_P2(6), .WDT_P3(8), .WAKE_SLOW(10)) dut (
    .clk(clk), .rst_n(rst_n), .lrc_tick(lrc_tick), .hrc_tick(hrc_tick), .xtal_tick(xtal_tick),
    .clock_mode_wr(clock_mode_wr), .clock_mode_wdata(clock_mode_wdata),
    .crystal_ctrl_wr(crystal_ctrl_wr), .crystal_ctrl_wdata(crystal_ctrl_wdata),
    .aux_ctrl_wr(aux_ctrl_wr), .aux_ctrl_wdata(aux_ctrl_wdata), .wdt_clear(wdt_clear),
    .por_done(por_done), .supply_low(supply_low), .light_stop(light_stop),
    .deep_stop(deep_stop), .wake_req(wake_req), .fast_wake_sel(fast_wake_sel),
    .clock_mode_q(clock_mode_q), .crystal_ctrl_q(crystal_ctrl_q), .aux_ctrl_q(aux_ctrl_q),
    .lrc_en(lrc_en), .hrc_en(hrc_en), .xtal_en(xtal_en), .xtal_drive(xtal_drive),
    .core_src(core_src), .core_tick(core_tick), .wdt_reset(wdt_reset),
    .brownout_reset(brownout_reset), .brownout_level(brownout_level), .wake_done(wake_done)
  );

  // ----------------------------------------
  // Oscillator ticks: periods of 5, 2 and 3 cycles
  // ----------------------------------------
  always @(posedge clk)
  begin
    #1;
    cyc++;
    lrc_tick  <= lrc_on && (cyc % 5 == 0);
    hrc_tick  <= hrc_on && (cyc % 2 == 0);
    xtal_tick <= xtal_on && (cyc % 3 == 0);
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task summarize;
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task timeout;
    mismatches++;
    summarize;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic do_reset;
    rst_n = 1'b0;
    {clock_mode_wr, crystal_ctrl_wr, aux_ctrl_wr, wdt_clear, por_done} = '0;
    {supply_low, light_stop, deep_stop, wake_req, fast_wake_sel} = '0;
    lrc_on = 1'b1;
    hrc_on = 1'b1;
    xtal_on = 1'b0;
    step(6);
    rst_n = 1'b1;
  endtask

  // Which: 0 clock mode, 1 crystal control, 2 auxiliary control
  task automatic wr_reg(input int which, input logic [7:0] d);
    clock_mode_wdata = d;
    crystal_ctrl_wdata = d;
    aux_ctrl_wdata = d;
    clock_mode_wr = (which == 0);
    crystal_ctrl_wr = (which == 1);
    aux_ctrl_wr = (which == 2);
    step(1);
    {clock_mode_wr, crystal_ctrl_wr, aux_ctrl_wr} = '0;
  endtask

  // Counts low-speed ticks until wake_done (wake=1) or wdt_reset (wake=0)
  task automatic count_until(input bit wake, output int n);
    n = 0;
    for (int i = 0; i < 1000; i++)
    begin
      @(posedge clk);
      if (wake ? wake_done : wdt_reset)
      begin
        #1;
        return;
      end
      if (lrc_tick)
        n++;
    end
    timeout;
  endtask

  // Counts pulses of core_tick (which=1) or wdt_reset (which=0) over a window
  task automatic count_pulses(input bit which, input int cycles, output int c);
    c = 0;
    repeat (cycles)
    begin
      @(posedge clk);
      c += which ? core_tick : wdt_reset;
    end
    #1;
  endtask

  // Cycles between two successive core ticks
  task automatic core_gap(output int g);
    int k;
    k = 0;
    g = 0;
    for (int i = 0; i < 400 && k < 2; i++)
    begin
      @(posedge clk);
      if (k == 1)
        g++;
      if (core_tick)
        k++;
    end
    #1;
    if (k < 2)
      timeout;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    do_reset;
    step(1);
    `CHK(clock_mode_q, `SYC_CM_RESET)
    `CHK(lrc_en, 1'b1)
    `CHK(hrc_en, 1'b1)
    `CHK(crystal_ctrl_q, 8'h00)
    `CHK(xtal_en, 1'b0)
    `CHK(aux_ctrl_q, 8'h00)
    `CHK(core_src, 2'h0)
    `CHK(brownout_level, 3'h0)
  endtask

  task automatic t_clock_paths;
    int g;
    do_reset;
    wr_reg(0, 8'h5e);
    `CHK(clock_mode_q, 8'h5e)
    core_gap(g);
    core_gap(g);
    `CHK(g, 80)
    wr_reg(0, `SYC_CM_HRC_DIV2);
    for (int i = 0; i < 300 && core_src !== 2'h1; i++)
      step(1);
    core_gap(g);
    `CHK(g, 4)
    `CHK(core_src, 2'h1)
    `CHK(lrc_en, 1'b1)
    wr_reg(0, 8'h32);
    `CHK(lrc_en, 1'b0)
    core_gap(g);
    `CHK(g, 4)
    core_gap(g);
    `CHK(g, 4)
  endtask

  task automatic t_xtal;
    int g;
    do_reset;
    for (int d = 1; d < 4; d++)
    begin
      wr_reg(1, 8'h80 | 8'(d << 5));
      `CHK(xtal_en, 1'b1)
      `CHK(xtal_drive, 2'(d))
    end
    xtal_on = 1'b1;
    step(20);
    wr_reg(0, `SYC_CM_XTAL);
    step(3);
    core_gap(g);
    `CHK(g, 3)
    `CHK(core_src, 2'h2)
    `CHK(lrc_en, 1'b1)
    `CHK(hrc_en, 1'b0)
  endtask

  task automatic t_stall;
    int c;
    do_reset;
    wr_reg(0, `SYC_CM_XTAL);
    step(3);
    `CHK(core_src, 2'h2)
    count_pulses(1'b1, 60, c);
    `CHK(c, 0)
  endtask

  task automatic t_wdt;
    int n;
    for (int s = 0; s < 4; s++)
    begin
      do_reset;
      lrc_on = 1'b0;
      wr_reg(2, 8'(s));
      wdt_clear = 1'b1;
      step(1);
      wdt_clear = 1'b0;
      lrc_on = 1'b1;
      count_until(1'b0, n);
      `CHK(n, wdt_p[s])
    end
    wr_reg(0, 8'hf4);
    count_pulses(1'b0, 150, n);
    `CHK(n, 0)
    wr_reg(0, 8'hf2);
    count_pulses(1'b0, 150, n);
    `CHK(n, 0)
  endtask

  task automatic t_bor;
    do_reset;
    supply_low = 1'b1;
    step(4);
    `CHK(brownout_reset, 1'b0)
    `CHK(brownout_level, 3'h0)
    por_done = 1'b1;
    step(1);
    por_done = 1'b0;
    step(3);
    `CHK(brownout_level, 3'h1)
    `CHK(brownout_reset, 1'b1)
    light_stop = 1'b1;
    step(2);
    `CHK(brownout_reset, 1'b0)
    light_stop = 1'b0;
    deep_stop = 1'b1;
    step(2);
    `CHK(brownout_reset, 1'b0)
    deep_stop = 1'b0;
    wr_reg(2, 8'h04);
    step(2);
    `CHK(brownout_reset, 1'b0)
    wr_reg(2, 8'h00);
    step(2);
    `CHK(brownout_reset, 1'b1)
  endtask

  task automatic t_wake;
    int n;
    for (int f = 1; f >= 0; f--)
    begin
      do_reset;
      fast_wake_sel = f[0];
      wake_req = 1'b1;
      step(1);
      wake_req = 1'b0;
      count_until(1'b1, n);
      `CHK(n, f ? 45 : 10)
    end
  endtask

  // Select codes 0 to 14, the last one refused, against tick period times divider
  task automatic t_codes;
    int g;
    int gap [15] = '{8, 4, 2, 12, 6, 3, 20, 5, 32, 16, 80, 64, 128, 24, 24};
    int src [15] = '{1, 1, 1, 2, 2, 2, 0, 0, 1, 1, 0, 1, 1, 2, 2};
    do_reset;
    xtal_on = 1'b1;
    wr_reg(1, 8'h80);
    for (int c = 0; c < 15; c++)
    begin
      wr_reg(0, {c[2:0], 1'b1, c[3], 1'b1, 2'b00});
      core_gap(g);
      core_gap(g);
      `CHK(g, gap[c])
      `CHK(core_src, 2'(src[c]))
    end
  endtask

  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    {lrc_tick, hrc_tick, xtal_tick, lrc_on, hrc_on, xtal_on} = '0;
    {clock_mode_wr, crystal_ctrl_wr, aux_ctrl_wr, wdt_clear, por_done} = '0;
    {supply_low, light_stop, deep_stop, wake_req, fast_wake_sel} = '0;
    {clock_mode_wdata, crystal_ctrl_wdata, aux_ctrl_wdata} = '0;
    cyc = 0;
    mismatches = 0;
    n_checks = 0;
    t_reset;
    t_clock_paths;
    t_xtal;
    t_stall;
    t_wdt;
    t_bor;
    t_wake;
    t_codes;
    summarize;
  end
endmodule
